// >>> rtl/lcpf_defs.vh
// constants for the link control packet framer
// Operation
// - control packets are four or eight bytes; all packets whole doublewords.
// - six-bit command code in bits 5:0 of byte 0 sets packet type.
// - unit identifier zero belongs only to the host bridge.
// - host-origin flag on responses set only when host bridge sent it.
// - equal nonzero sequence tags stay ordered; tag zero means unsequenced.
// - forwarding keeps same-stream matching nonzero sequence tags in order.
// - pass-posted set may overtake posted requests; originators leave it clear.
// - at most 32 outstanding per unit; unit plus tag unique, matches responses.
// - transaction tag is reserved in posted requests.
// - address field carries doubleword address bits 63 down to 2; code carries bits 63:8 only.
// - reserved fields sent as zero, undefined on receive, forwarded unchanged.
// - info packets are four bytes, never routed, always accepted.
// - request is eight bytes with address, four bytes without.
// - request byte layout of tag, command, pass-posted, unit and address.
// - address extension only before read, write, broadcast or atomic request.
// - extension never sent alone; ordered with its request as one unit.
// - missing address extension means address bits 63:40 are zero.
// - address extension: top bits 00, code 111110, bytes carry bits 63:40.
// - extension kind told apart by the top two bits of byte 0.
// - source extensions generated only when enabled on the link.
// - source extension top bits 10; 01 and 11 are reserved.
`ifndef LCPF_DEFS_VH
`define LCPF_DEFS_VH
`define LCPF_F_CMD 5:0
`define LCPF_F_SEQHI 7:6
`define LCPF_F_UNIT 12:8
`define LCPF_F_SEQLO 14:13
`define LCPF_B_PP 15
`define LCPF_F_TAG 20:16
`define LCPF_F_CSHI 31:21
`define LCPF_F_CSPEC 31:16
`define LCPF_F_EXTTOP 7:6
`define LCPF_F_EXTPAY 31:8
`define LCPF_F_AHI 63:40
`define LCPF_F_ALO 39:8
`define LCPF_CMD_EXT 6'h3E
`define LCPF_CMD_NOP 6'h00
`define LCPF_EXT_ADDR 2'h0
`define LCPF_EXT_SRC 2'h2
`define LCPF_UNIT_HOST 5'h00
`define LCPF_SEQ_NONE 4'h0
`define LCPF_ST_IDLE 2'h0
`define LCPF_ST_AEXT 2'h1
`define LCPF_ST_REQ0 2'h2
`define LCPF_ST_REQ1 2'h3
`endif

// >>> rtl/lcpf_framer.v
// control packet framer: builds and parses link control doublewords
`timescale 1ns/100ps
`include "lcpf_defs.vh"
module lcpf_framer (
  // clock and reset
  input wire clk,
  input wire srst,
  // link configuration
  input wire is_host_bridge,
  input wire addr64_en,
  input wire srcid_gen_en,
  // transmit request
  input wire tx_req_valid,
  output wire tx_req_ready,
  input wire [5:0] tx_cmd,
  input wire [3:0] tx_seq_tag,
  input wire tx_pass_posted,
  input wire [4:0] tx_unit_id,
  input wire [4:0] tx_txn_tag,
  input wire tx_posted,
  input wire [10:0] tx_cmd_spec,
  input wire tx_has_addr,
  input wire tx_ext_cmd,
  input wire [63:8] tx_addr,
  input wire [23:0] tx_srcid,
  output reg tx_req_err,
  // transmit info
  input wire tx_info_valid,
  output wire tx_info_ready,
  input wire [31:0] tx_info_word,
  // link out
  output reg tx_dw_valid,
  input wire tx_dw_ready,
  output reg [31:0] tx_dw,
  // link in
  input wire rx_dw_valid,
  input wire [31:0] rx_dw,
  // received info
  output reg rx_info_valid,
  output reg [31:0] rx_info_word,
  // received request
  output reg rx_req_valid,
  output reg [5:0] rx_cmd,
  output reg [3:0] rx_seq_tag,
  output reg rx_seq_ordered,
  output reg rx_pass_posted,
  output reg [4:0] rx_unit_id,
  output reg rx_from_host,
  output reg [15:0] rx_cmd_spec,
  output reg rx_has_addr,
  output reg [63:8] rx_addr,
  output reg rx_srcid_valid,
  output reg [23:0] rx_srcid,
  output reg rx_ext_err
);

  // transmit state
  reg [1:0] st_reg;
  reg [1:0] st_next;
  reg [31:0] w0_reg;
  reg [31:0] w1_reg;
  reg [31:0] aext_reg;
  reg has_addr_reg;
  reg [31:0] dw_next;
  reg dv_next;
  reg err_next;
  wire out_free;
  wire idle;
  wire is_rd;
  wire is_wr;
  wire ext_ok;
  wire need_aext;
  wire bad_unit;
  wire bad_ext;
  wire take;
  wire [4:0] tag_fld;
  wire [31:0] w0_new;
  wire [31:0] aext_new;
  wire [31:0] sext_new;

  assign out_free = !tx_dw_valid || tx_dw_ready;
  assign idle = (st_reg == `LCPF_ST_IDLE);
  // info waits only for an idle framer and a free output: it wins over a new request
  assign tx_info_ready = idle && out_free;
  // no packet may split an extension from its request
  assign tx_req_ready = idle && out_free && !tx_info_valid;
  assign take = tx_req_valid && tx_req_ready;
  assign is_rd = (tx_cmd[5:4] == 2'h1);
  assign is_wr = (tx_cmd[4:3] == 2'h1);
  // extension only for read, write, broadcast or atomic
  assign ext_ok = tx_has_addr && (is_rd || is_wr || tx_ext_cmd);
  // upper address zero means no address extension is sent
  assign need_aext = addr64_en && (|tx_addr[`LCPF_F_AHI]);
  // unit zero reserved to the host bridge
  assign bad_unit = !is_host_bridge
    && (tx_unit_id == `LCPF_UNIT_HOST);
  assign bad_ext = (|tx_addr[`LCPF_F_AHI])
    && !(ext_ok && addr64_en);
  // tag reserved and driven zero in posted requests
  assign tag_fld = tx_posted ? 5'h00 : tx_txn_tag;
  // request doubleword 0 layout
  assign w0_new = {tx_cmd_spec, tag_fld, tx_pass_posted,
    tx_seq_tag[1:0], tx_unit_id, tx_seq_tag[3:2], tx_cmd};
  // address extension: 00b, extension code, bits 63:40
  assign aext_new = {tx_addr[`LCPF_F_AHI], `LCPF_EXT_ADDR,
    `LCPF_CMD_EXT};
  // source extension: 10b, extension code, identifier
  assign sext_new = {tx_srcid, `LCPF_EXT_SRC, `LCPF_CMD_EXT};

  always @* begin
    st_next = st_reg;
    dw_next = tx_dw;
    dv_next = tx_dw_valid && !tx_dw_ready;
    err_next = 1'b0;
    if (out_free) begin
      case (st_reg)
        `LCPF_ST_IDLE: begin
          if (tx_info_valid) begin
            dw_next = tx_info_word;
            dv_next = 1'b1;
          end else if (take && (bad_unit || bad_ext)) begin
            err_next = 1'b1;
          end else if (take) begin
            dv_next = 1'b1;
            if (srcid_gen_en) begin
              // source extension first, only when enabled
              dw_next = sext_new;
              st_next = (ext_ok && need_aext) ? `LCPF_ST_AEXT
                : `LCPF_ST_REQ0;
            end else if (ext_ok && need_aext) begin
              dw_next = aext_new;
              st_next = `LCPF_ST_REQ0;
            end else begin
              dw_next = w0_new;
              // four-byte form omits the address
              st_next = tx_has_addr ? `LCPF_ST_REQ1
                : `LCPF_ST_IDLE;
            end
          end
        end
        `LCPF_ST_AEXT: begin
          dw_next = aext_reg;
          dv_next = 1'b1;
          st_next = `LCPF_ST_REQ0;
        end
        `LCPF_ST_REQ0: begin
          dw_next = w0_reg;
          dv_next = 1'b1;
          st_next = has_addr_reg ? `LCPF_ST_REQ1 : `LCPF_ST_IDLE;
        end
        `LCPF_ST_REQ1: begin
          // address bits 39:8 in bytes 4 to 7
          dw_next = w1_reg;
          dv_next = 1'b1;
          st_next = `LCPF_ST_IDLE;
        end
        default: begin
          st_next = `LCPF_ST_IDLE;
          dv_next = 1'b0;
        end
      endcase
    end
  end

  always @(posedge clk) begin
    if (srst) begin
      st_reg <= `LCPF_ST_IDLE;
      tx_dw_valid <= 1'b0;
      tx_dw <= 32'h00000000;
      tx_req_err <= 1'b0;
      w0_reg <= 32'h00000000;
      w1_reg <= 32'h00000000;
      aext_reg <= 32'h00000000;
      has_addr_reg <= 1'b0;
    end else begin
      st_reg <= st_next;
      tx_dw_valid <= dv_next;
      tx_dw <= dw_next;
      tx_req_err <= err_next;
      if (take) begin
        w0_reg <= w0_new;
        w1_reg <= tx_addr[`LCPF_F_ALO];
        aext_reg <= aext_new;
        has_addr_reg <= tx_has_addr;
      end
    end
  end

  // receive state
  reg need1_reg;
  reg ha_v_reg;
  reg [23:0] ha_val_reg;
  reg hs_v_reg;
  reg [23:0] hs_val_reg;
  wire [5:0] rcmd;
  wire [1:0] rtop;
  wire r_is_ext;
  wire r_is_info;
  wire r_addr;

  // type decoded from the command code alone
  assign rcmd = rx_dw[`LCPF_F_CMD];
  assign rtop = rx_dw[`LCPF_F_EXTTOP];
  assign r_is_ext = (rcmd == `LCPF_CMD_EXT);
  assign r_is_info = (rcmd == `LCPF_CMD_NOP);
  assign r_addr = (rcmd[5:4] == 2'h1) || (rcmd[4:3] == 2'h1);

  always @(posedge clk) begin
    if (srst) begin
      need1_reg <= 1'b0;
      ha_v_reg <= 1'b0;
      ha_val_reg <= 24'h000000;
      hs_v_reg <= 1'b0;
      hs_val_reg <= 24'h000000;
      rx_info_valid <= 1'b0;
      rx_info_word <= 32'h00000000;
      rx_req_valid <= 1'b0;
      rx_cmd <= 6'h00;
      rx_seq_tag <= 4'h0;
      rx_seq_ordered <= 1'b0;
      rx_pass_posted <= 1'b0;
      rx_unit_id <= 5'h00;
      rx_from_host <= 1'b0;
      rx_cmd_spec <= 16'h0000;
      rx_has_addr <= 1'b0;
      rx_addr <= 56'h00000000000000;
      rx_srcid_valid <= 1'b0;
      rx_srcid <= 24'h000000;
      rx_ext_err <= 1'b0;
    end else begin
      rx_info_valid <= 1'b0;
      rx_req_valid <= 1'b0;
      rx_ext_err <= 1'b0;
      if (rx_dw_valid) begin
        if (need1_reg) begin
          // second doubleword: low address, attach held extension
          need1_reg <= 1'b0;
          rx_req_valid <= 1'b1;
          rx_addr[`LCPF_F_ALO] <= rx_dw;
          rx_addr[`LCPF_F_AHI] <= ha_v_reg ? ha_val_reg
            : 24'h000000;
          rx_srcid_valid <= hs_v_reg;
          rx_srcid <= hs_val_reg;
          ha_v_reg <= 1'b0;
          hs_v_reg <= 1'b0;
        end else if (r_is_ext) begin
          // extension kind from the top two bits
          if (rtop == `LCPF_EXT_ADDR) begin
            ha_v_reg <= 1'b1;
            ha_val_reg <= rx_dw[`LCPF_F_EXTPAY];
          end else if (rtop == `LCPF_EXT_SRC) begin
            hs_v_reg <= 1'b1;
            hs_val_reg <= rx_dw[`LCPF_F_EXTPAY];
          end else begin
            rx_ext_err <= 1'b1;
          end
        end else if (r_is_info) begin
          // info always accepted, held extensions kept
          rx_info_valid <= 1'b1;
          rx_info_word <= rx_dw;
        end else begin
          // reserved and command-specific bits passed raw
          rx_cmd <= rcmd;
          rx_seq_tag <= {rx_dw[`LCPF_F_SEQHI],
            rx_dw[`LCPF_F_SEQLO]};
          rx_seq_ordered <= ({rx_dw[`LCPF_F_SEQHI],
            rx_dw[`LCPF_F_SEQLO]} != `LCPF_SEQ_NONE);
          rx_pass_posted <= rx_dw[`LCPF_B_PP];
          rx_unit_id <= rx_dw[`LCPF_F_UNIT];
          rx_from_host <= (rx_dw[`LCPF_F_UNIT]
            == `LCPF_UNIT_HOST);
          rx_cmd_spec <= rx_dw[`LCPF_F_CSPEC];
          rx_has_addr <= r_addr;
          if (r_addr) begin
            need1_reg <= 1'b1;
          end else begin
            rx_req_valid <= 1'b1;
            rx_addr <= 56'h00000000000000;
            rx_srcid_valid <= hs_v_reg;
            rx_srcid <= hs_val_reg;
            ha_v_reg <= 1'b0;
            hs_v_reg <= 1'b0;
          end
        end
      end
    end
  end

endmodule // lcpf_framer

// >>> sim/lcpf_framer_chk.sv
// port assertions for the control packet framer
`timescale 1ns/100ps
module lcpf_framer_chk (
  // clock and configuration
  input wire clk,
  input wire srst,
  input wire is_host_bridge,
  input wire addr64_en,
  input wire srcid_gen_en,
  // transmit side
  input wire tx_req_valid,
  input wire tx_req_ready,
  input wire [5:0] tx_cmd,
  input wire [4:0] tx_unit_id,
  input wire [63:8] tx_addr,
  input wire tx_req_err,
  input wire tx_info_ready,
  input wire tx_dw_valid,
  input wire tx_dw_ready,
  input wire [31:0] tx_dw,
  // receive side
  input wire rx_dw_valid,
  input wire [31:0] rx_dw,
  input wire rx_req_valid,
  input wire [3:0] rx_seq_tag,
  input wire rx_seq_ordered,
  input wire [4:0] rx_unit_id,
  input wire rx_from_host,
  input wire rx_ext_err
);
  default clocking dc @(posedge clk); endclocking
  default disable iff (srst);
  a_req_answer: assert property (
    tx_req_valid && tx_req_ready |=> tx_dw_valid || tx_req_err)
    else $error("taken request gave no answer");
  a_dw_hold: assert property (
    tx_dw_valid && !tx_dw_ready |=> tx_dw_valid && $stable(tx_dw))
    else $error("stalled dword not held");
  a_stall_block: assert property (
    tx_dw_valid && !tx_dw_ready |-> !tx_req_ready && !tx_info_ready)
    else $error("new packet offered while output stalled");
  a_unit_refuse: assert property (
    tx_req_valid && tx_req_ready && !is_host_bridge && tx_unit_id == 5'h00
    |=> tx_req_err && !tx_dw_valid) else $error("unit zero not refused");
  a_dw0_layout: assert property (
    tx_req_valid && tx_req_ready && !addr64_en && !srcid_gen_en
    && tx_addr[63:40] == 24'h000000 && tx_unit_id != 5'h00
    |=> tx_dw_valid && tx_dw[5:0] == $past(tx_cmd))
    else $error("first dword lacks command code");
  a_host_flag: assert property (
    rx_req_valid |-> rx_from_host == (rx_unit_id == 5'h00))
    else $error("host flag disagrees with unit");
  a_seq_order: assert property (
    rx_req_valid |-> rx_seq_ordered == (rx_seq_tag != 4'h0))
    else $error("ordered flag disagrees with tag");
  a_ext_err: assert property (
    rx_dw_valid && rx_dw[5:0] == 6'h3E && rx_dw[6] |=> rx_ext_err)
    else $error("reserved extension kind not flagged");
endmodule // lcpf_framer_chk

// >>> sim/lcpf_link_peer.sv
// peer link model: collects framer dwords and feeds dwords back
`timescale 1ns/100ps
module lcpf_link_peer (
  // clock
  input wire clk,
  // framer output stream
  input wire tx_dw_valid,
  output wire tx_dw_ready,
  input wire [31:0] tx_dw,
  // framer input stream
  output logic rx_dw_valid,
  output logic [31:0] rx_dw,
  // slow peer control
  input wire stall
);
  logic [31:0] got[$];
  assign tx_dw_ready = !stall;
  initial begin
    rx_dw_valid = 1'b0;
    rx_dw = 32'h00000000;
  end
  always @(posedge clk) begin
    if (tx_dw_valid && tx_dw_ready) begin
      got.push_back(tx_dw);
    end
  end
  // send drives one dword with valid from the next falling edge
  task send(input logic [31:0] dw);
    @(negedge clk);
    rx_dw_valid = 1'b1;
    rx_dw = dw;
  endtask
  task idle;
    @(negedge clk);
    rx_dw_valid = 1'b0;
    rx_dw = ~rx_dw;
  endtask
endmodule // lcpf_link_peer

// >>> sim/lcpf_framer_tb.sv
// self-checking bench for the control packet framer
`timescale 1ns/100ps
module lcpf_framer_tb;
  logic clk = 1'b0;
  logic srst = 1'b1;
  logic is_host_bridge = 1'b0, addr64_en = 1'b0, srcid_gen_en = 1'b0;
  logic tx_req_valid = 1'b0, tx_pass_posted = 1'b0, tx_posted = 1'b0;
  logic tx_has_addr = 1'b0, tx_ext_cmd = 1'b0, tx_info_valid = 1'b0;
  logic stall = 1'b0;
  logic [5:0] tx_cmd = 6'h00;
  logic [3:0] tx_seq_tag = 4'h0;
  logic [4:0] tx_unit_id = 5'h00, tx_txn_tag = 5'h00;
  logic [10:0] tx_cmd_spec = 11'h5A5;
  logic [63:8] tx_addr = 56'h0;
  logic [23:0] tx_srcid = 24'h012345;
  logic [31:0] tx_info_word = 32'h00000000;
  wire tx_req_ready, tx_req_err, tx_info_ready, tx_dw_valid, tx_dw_ready;
  wire rx_dw_valid, rx_info_valid, rx_req_valid, rx_seq_ordered;
  wire rx_pass_posted, rx_from_host, rx_has_addr, rx_srcid_valid, rx_ext_err;
  wire [31:0] tx_dw, rx_dw, rx_info_word;
  wire [5:0] rx_cmd;
  wire [3:0] rx_seq_tag;
  wire [4:0] rx_unit_id;
  wire [15:0] rx_cmd_spec;
  wire [63:8] rx_addr;
  wire [23:0] rx_srcid;
  int mismatches = 0;
  int comparisons = 0;
  lcpf_framer dut (.*);
  lcpf_link_peer peer (.clk(clk), .tx_dw_valid(tx_dw_valid),
    .tx_dw_ready(tx_dw_ready), .tx_dw(tx_dw), .rx_dw_valid(rx_dw_valid),
    .rx_dw(rx_dw), .stall(stall));
  initial forever #20 clk = ~clk;
  task check(input logic [63:0] seen, input logic [63:0] exp);
    comparisons++;
    if (seen !== exp) begin
      mismatches++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  function automatic logic [31:0] got1;
    got1 = 32'hXXXXXXXX;
    if (peer.got.size() != 0)
      got1 = peer.got.pop_front();
  endfunction
  function automatic logic [31:0] dw0(input logic [5:0] c,
    input logic [3:0] s, input logic [4:0] u);
    dw0 = {11'h5A5, c[5] ? 5'h00 : {1'b0, s}, s[0], s[1:0], u, s[3:2], c};
  endfunction
  task settle;
    int n;
    n = 0;
    @(negedge clk);
    while ((!tx_req_ready || tx_dw_valid) && n < 100) begin
      @(negedge clk);
      n++;
    end
    if (n >= 100) begin
      mismatches++;
    end
  endtask
  task t_tx_info;
    settle;
    tx_info_word = 32'h00C0FFEE;
    tx_info_valid = 1'b1;
    @(negedge clk);
    tx_info_valid = 1'b0;
    check(tx_dw, 32'h00C0FFEE);
    settle;
    check(got1(), 32'h00C0FFEE);
  endtask
  task req(input logic [5:0] c, input logic [3:0] s, input logic [4:0] u,
    input logic h, input logic [63:8] a);
    settle;
    tx_cmd = c;
    tx_seq_tag = s;
    tx_unit_id = u;
    tx_has_addr = h;
    tx_addr = a;
    tx_posted = c[5];
    tx_txn_tag = {1'b0, s};
    tx_pass_posted = s[0];
    tx_req_valid = 1'b1;
    @(negedge clk);
    tx_req_valid = 1'b0;
  endtask
  task t_tx_plain;
    stall = 1'b1;
    req(6'h14, 4'h9, 5'h03, 1'b1, 56'h00000012345678);
    repeat (2) @(negedge clk);
    check(tx_dw, dw0(6'h14, 4'h9, 5'h03));
    check(tx_req_ready, 1'b0);
    stall = 1'b0;
    settle;
    check(got1(), dw0(6'h14, 4'h9, 5'h03));
    check(got1(), 32'h12345678);
    req(6'h2D, 4'h3, 5'h03, 1'b1, 56'h0000000000AB00);
    settle;
    check(got1(), dw0(6'h2D, 4'h3, 5'h03));
    check(got1(), 32'h0000AB00);
    req(6'h02, 4'h0, 5'h03, 1'b0, 56'h0);
    settle;
    check(got1(), dw0(6'h02, 4'h0, 5'h03));
    check(peer.got.size(), 0);
  endtask
  task t_tx_ext;
    addr64_en = 1'b1;
    srcid_gen_en = 1'b1;
    req(6'h14, 4'h2, 5'h04, 1'b1, 56'hABCDEF89ABCDEF);
    settle;
    check(got1(), 32'h012345BE);
    check(got1(), 32'hABCDEF3E);
    check(got1(), dw0(6'h14, 4'h2, 5'h04));
    check(got1(), 32'h89ABCDEF);
    addr64_en = 1'b0;
    srcid_gen_en = 1'b0;
  endtask
  task t_tx_refuse;
    req(6'h14, 4'h1, 5'h00, 1'b1, 56'h0);
    check(tx_req_err, 1'b1);
    req(6'h14, 4'h1, 5'h05, 1'b1, 56'h01000000000000);
    check(tx_req_err, 1'b1);
    is_host_bridge = 1'b1;
    req(6'h14, 4'h1, 5'h00, 1'b1, 56'h0);
    settle;
    check(got1(), dw0(6'h14, 4'h1, 5'h00));
    check(got1(), 32'h00000000);
    check(peer.got.size(), 0);
    is_host_bridge = 1'b0;
  endtask
  task t_rx;
    peer.send(32'hABCDEF3E);
    peer.send(dw0(6'h14, 4'h6, 5'h00));
    peer.send(32'h89ABCDEF);
    peer.idle;
    check(rx_req_valid, 1'b1);
    check(rx_addr, 56'hABCDEF89ABCDEF);
    check(rx_from_host, 1'b1);
    check(rx_seq_tag, 4'h6);
    check({rx_pass_posted, rx_cmd_spec}, 17'h0B4A6);
    peer.send(dw0(6'h14, 4'h0, 5'h05));
    peer.send(32'h89ABCDEF);
    peer.idle;
    check(rx_addr, 56'h00000089ABCDEF);
    check(rx_seq_ordered, 1'b0);
    peer.send(32'h012345BE);
    peer.send(32'h11223300);
    peer.idle;
    check({rx_info_valid, rx_info_word}, 33'h111223300);
    peer.send(dw0(6'h02, 4'h0, 5'h05));
    peer.idle;
    check({rx_srcid_valid, rx_srcid}, 25'h1012345);
    check({rx_has_addr, rx_cmd}, 7'h02);
    for (int i = 0; i < 2; i++) begin
      peer.send({24'h000000, i ? 8'hFE : 8'h7E});
      peer.idle;
      check(rx_ext_err, 1'b1);
    end
  endtask
  task tally_and_finish;
    $display("comparisons=%0d mismatches=%0d", comparisons, mismatches);
    if (mismatches == 0 && comparisons > 0) begin
      $display("verification passed");
    end else begin
      $display("verification failed");
    end
    $finish;
  endtask
  initial begin
    repeat (10) @(negedge clk);
    srst = 1'b0;
    t_tx_plain;
    t_tx_ext;
    t_tx_refuse;
    t_tx_info;
    t_rx;
    tally_and_finish;
  end
  initial begin
    #100000;
    mismatches++;
    tally_and_finish;
  end
endmodule // lcpf_framer_tb
bind lcpf_framer lcpf_framer_chk chk (.*);
